// file: verilog/rst_pkg.sv
// Package of the rail sequence timers: timing constants and states.
// Assumes a single 25 MHz clock domain.
package rst_pkg;

  localparam int          RST_CLK_MHZ      = 25;
  localparam int          RST_NRAILS       = 4;
  // Programmed duration limits, in microseconds
  localparam int          RST_TMIN_US      = 250;
  localparam int          RST_TMAX_US      = 25000;
  localparam int          RST_TMIN_CYC     = RST_TMIN_US * RST_CLK_MHZ;
  localparam int          RST_TMAX_CYC     = RST_TMAX_US * RST_CLK_MHZ;
  // Worst-case step without delay, in nanoseconds
  localparam int          RST_TPD_NS       = 6500;
  localparam int          RST_TPD_CYC      = (RST_TPD_NS * RST_CLK_MHZ) / 1000;
  localparam int          RST_TW           = 20;
  localparam logic [19:0] RST_CNT_RST      = 20'h00000;
  localparam logic [3:0]  RST_EN_RST       = 4'h0;
  localparam logic [1:0]  RST_IDX_RST      = 2'h0;
  // Synchroniser idle: down high, rails below off level
  localparam logic [14:0] RST_SYNC_RST     = 15'h40F0;

  typedef enum logic [4:0] {
    RST_IDLE  = 5'h01,
    RST_UPWT  = 5'h02,
    RST_UPDLY = 5'h04,
    RST_DNWT  = 5'h08,
    RST_DNDLY = 5'h10
  } rst_state_t;

endpackage

// file: verilog/rst_tmr_if.sv
// Interface between the sequencer core and its two timers.
// Assumes both ends share mclk.
`timescale 1ns/1ps
`default_nettype none
interface rst_tmr_if;
  logic        start;
  logic        stop;
  logic        enabled;
  logic [19:0] limit;
  logic        expired;
  logic        running;
  modport ctl (output start, output stop, output enabled, output limit,
               input expired, input running);
  modport tmr (input start, input stop, input enabled, input limit,
               output expired, output running);
endinterface
`default_nettype wire

// file: verilog/rst_timer.sv
// One shared timer counting mclk cycles up to a configured limit.
// Assumes the limit stays fixed after power-up.
`timescale 1ns/1ps
`default_nettype none
module rst_timer
  import rst_pkg::*;
(
  input  wire logic mclk,  // System clock
  input  wire logic nrst,  // Async reset, active low
  rst_tmr_if.tmr    t      // Control from core
);
  typedef struct packed {
    logic [19:0] cnt;
    logic        run;
    logic        exp;
  } rst_tmr_st_t;

  rst_tmr_st_t s_q;
  rst_tmr_st_t s_d;
  logic [19:0] lim;

  // Clamp to the supported range
  always_comb begin
    if (t.limit < 20'(RST_TMIN_CYC)) begin
      lim = 20'(RST_TMIN_CYC);
    end else if (t.limit > 20'(RST_TMAX_CYC)) begin
      lim = 20'(RST_TMAX_CYC);
    end else begin
      lim = t.limit;
    end
  end

  always_comb begin
    s_d     = s_q;
    s_d.exp = 1'b0;
    if (t.start) begin
      s_d.cnt = RST_CNT_RST;
      s_d.run = t.enabled;
    end else if (t.stop) begin
      s_d.run = 1'b0;
    end else if (s_q.run) begin
      if (s_q.cnt >= lim - 20'h00001) begin
        s_d.run = 1'b0;
        s_d.exp = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 20'h00001;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign t.expired = s_q.exp;
  assign t.running = s_q.run;

  a_exp_after_run: assert property (@(posedge mclk)
    disable iff (!nrst) t.expired |-> $past(s_q.run))
    else $error("expiry without run");
endmodule
`default_nettype wire

// file: verilog/rst_sequencer.sv
// Timing core of a four-rail power sequencer with shared timers.
// Assumes monitor and command pins are asynchronous, mclk 25 MHz.
`timescale 1ns/1ps
`default_nettype none
module rst_sequencer
  import rst_pkg::*;
(
  input  wire logic        mclk,                    // 25 MHz clock
  input  wire logic        nrst,                    // Async reset
  input  wire logic        main_supply_ok,          // Main supply above POR
  input  wire logic [3:0]  rail_on_level,           // Rail above on level
  input  wire logic [3:0]  rail_off_level,          // Rail below off level
  input  wire logic [3:0]  rail_monitor_input,      // Monitor tied high
  input  wire logic        up_cmd,                  // Up command pin
  input  wire logic        down_cmd_n,              // Down command pin
  input  wire logic        step_delay_connected,    // Delay config present
  input  wire logic [19:0] step_delay_cycles,       // Delay length
  input  wire logic        regulation_connected,    // Timeout config present
  input  wire logic [19:0] regulation_cycles,       // Timeout length
  output logic      [3:0]  rail_enable,             // Regulator enables
  output logic             sequence_complete_flag,  // Sequence done
  output logic             power_good_flag          // Power good
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int SW = 15;
  logic [SW-1:0] sy1_q;
  logic [SW-1:0] sy2_q;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      // Idle levels, so no false command edge follows reset
      sy1_q <= RST_SYNC_RST;
      sy2_q <= RST_SYNC_RST;
    end else begin
      sy1_q <= {down_cmd_n, up_cmd, main_supply_ok, rail_monitor_input,
                rail_off_level, rail_on_level};
      sy2_q <= sy1_q;
    end
  end
  logic [3:0] on_s;
  logic [3:0] off_s;
  logic [3:0] skip_s;
  logic       por_s;
  logic       up_s;
  logic       dn_s;
  assign on_s   = sy2_q[3:0];
  assign off_s  = sy2_q[7:4];
  // rail 1 can never be skipped
  assign skip_s = {sy2_q[11:9], 1'b0};
  assign por_s  = sy2_q[12];
  assign up_s   = sy2_q[13];
  assign dn_s   = sy2_q[14];

  // ----------------------------------------------------------------
  // Shared timers
  // ----------------------------------------------------------------
  rst_tmr_if dly_if ();
  rst_tmr_if reg_if ();
  rst_timer u_step_delay_timer (
    .mclk (mclk),
    .nrst (nrst),
    .t    (dly_if.tmr)
  );
  rst_timer u_regulation_timeout (
    .mclk (mclk),
    .nrst (nrst),
    .t    (reg_if.tmr)
  );
  assign dly_if.enabled = step_delay_connected;
  assign reg_if.enabled = regulation_connected;
  assign dly_if.limit   = step_delay_cycles;
  assign reg_if.limit   = regulation_cycles;

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  typedef struct packed {
    rst_state_t  st;
    logic [1:0]  idx;
    logic [3:0]  en;
    logic        done;
    logic        pg;
    logic        up_prev;
    logic        dn_prev;
  } rst_seq_st_t;

  rst_seq_st_t s_q;
  rst_seq_st_t s_d;

  // Highest active rail, skipped rails are always the upper ones
  function automatic logic [1:0] last_rail(input logic [3:0] skip);
    logic [1:0] r;
    r = 2'h3;
    for (int i = 3; i >= 1; i--) begin
      if (skip[i]) begin
        r = 2'(i - 1);
      end
    end
    return r;
  endfunction

  logic       up_evt;
  logic       dn_evt;
  logic [1:0] top;
  logic       dly_done;

  assign up_evt = up_s && !s_q.up_prev;
  assign dn_evt = !dn_s && s_q.dn_prev;
  assign top    = last_rail(skip_s);
  // no timer means the step follows in a cycle
  // with timer the step waits for expiry
  assign dly_done = step_delay_connected ? dly_if.expired : 1'b1;

  always_comb begin
    s_d            = s_q;
    s_d.up_prev    = up_s;
    s_d.dn_prev    = dn_s;
    dly_if.start   = 1'b0;
    dly_if.stop    = 1'b0;
    reg_if.start   = 1'b0;
    reg_if.stop    = 1'b0;
    // power good falls on the down command
    if (dn_evt) begin
      s_d.pg = 1'b0;
    end
    unique case (s_q.st)
      RST_IDLE: begin
        if (up_evt && !dn_evt) begin
          s_d.idx      = RST_IDX_RST;
          s_d.en[0]    = 1'b1;
          s_d.st       = RST_UPWT;
          reg_if.start = 1'b1;
        end else if (dn_evt && s_q.en != RST_EN_RST) begin
          s_d.idx = top;
          s_d.st  = RST_DNWT;
        end
      end
      RST_UPWT: begin
        if (dn_evt) begin
          reg_if.stop = 1'b1;
          s_d.st      = RST_DNWT;
        end else if (on_s[s_q.idx]) begin
          // next enable and flags wait for the delay
          reg_if.stop  = 1'b1;
          dly_if.start = 1'b1;
          s_d.st       = RST_UPDLY;
        end else if (reg_if.expired) begin
          // reverse down from the previous rail
          s_d.en[s_q.idx] = 1'b0;
          s_d.pg          = 1'b0;
          if (s_q.idx == RST_IDX_RST) begin
            s_d.st = RST_IDLE;
          end else begin
            s_d.idx = s_q.idx - 2'h1;
            s_d.st  = RST_DNWT;
          end
        end
      end
      RST_UPDLY: begin
        if (dn_evt) begin
          dly_if.stop = 1'b1;
          s_d.st      = RST_DNWT;
        end else if (dly_done) begin
          if (s_q.idx == top) begin
            // both flags rise after the last rail
            s_d.done = 1'b1;
            s_d.pg   = 1'b1;
            s_d.st   = RST_IDLE;
          end else begin
            // upper skipped rails are never reached
            s_d.idx          = s_q.idx + 2'h1;
            s_d.en[s_q.idx + 2'h1] = 1'b1;
            reg_if.start     = 1'b1;
            s_d.st           = RST_UPWT;
          end
        end
      end
      RST_DNWT: begin
        // regulation timeout idle while going down
        s_d.en[s_q.idx] = 1'b0;
        if (up_evt) begin
          s_d.en[s_q.idx] = s_q.en[s_q.idx];
          s_d.st          = RST_UPWT;
          reg_if.start    = 1'b1;
        end else if (!s_q.en[s_q.idx] && off_s[s_q.idx]) begin
          dly_if.start = 1'b1;
          s_d.st       = RST_DNDLY;
        end
      end
      RST_DNDLY: begin
        if (dly_done) begin
          if (s_q.idx == RST_IDX_RST) begin
            // complete falls after the first rail
            s_d.done = 1'b0;
            s_d.st   = RST_IDLE;
          end else begin
            s_d.idx = s_q.idx - 2'h1;
            s_d.st  = RST_DNWT;
          end
        end
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: RST_IDLE, idx: RST_IDX_RST, en: RST_EN_RST,
               done: 1'b0, pg: 1'b0, up_prev: 1'b0, dn_prev: 1'b1};
    end else if (!por_s) begin
      // everything low below the power-on level
      s_q <= '{st: RST_IDLE, idx: RST_IDX_RST, en: RST_EN_RST,
               done: 1'b0, pg: 1'b0, up_prev: up_s, dn_prev: dn_s};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // driven high and low from flip-flops
  assign rail_enable            = s_q.en;
  assign sequence_complete_flag = s_q.done;
  assign power_good_flag        = s_q.pg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [3:0] cur_bit;
  logic [3:0] next_bit;
  assign cur_bit  = 4'h1 << s_q.idx;
  assign next_bit = 4'h1 << (s_q.idx + 2'h1);

  a_pg_drop_down: assert property (@(posedge mclk)
    disable iff (!nrst) dn_evt |=> !power_good_flag)
    else $error("power good held");
  a_reset_low_por: assert property (@(posedge mclk)
    disable iff (!nrst) !por_s |=> (rail_enable == 4'h0
    && !power_good_flag && !sequence_complete_flag))
    else $error("outputs not low below power-on level");
  a_up_hold_delay: assert property (@(posedge mclk)
    disable iff (!nrst) (s_q.st == RST_UPDLY && !dly_done && !dn_evt
    && por_s) |=> $stable(rail_enable))
    else $error("early enable");
  a_pg_with_done: assert property (@(posedge mclk)
    disable iff (!nrst) $rose(power_good_flag)
    |-> $rose(sequence_complete_flag))
    else $error("pg without done");
  a_reg_not_down: assert property (@(posedge mclk)
    disable iff (!nrst) (s_q.st == RST_DNWT || s_q.st == RST_DNDLY)
    |-> !reg_if.start || up_evt)
    else $error("timeout in down");
  a_reg_start_en: assert property (@(posedge mclk)
    disable iff (!nrst) (reg_if.start && s_q.st != RST_DNWT && por_s)
    |=> rail_enable[s_q.idx])
    else $error("timeout start");
  a_fast_step: assert property (@(posedge mclk)
    disable iff (!nrst)
    (!step_delay_connected && s_q.st == RST_UPDLY && !dn_evt)
    |=> s_q.st != RST_UPDLY)
    else $error("slow step");
  a_skip_not_en: assert property (@(posedge mclk)
    disable iff (!nrst) (skip_s[3] && $stable(skip_s))
    |=> !rail_enable[3] || $past(rail_enable[3]))
    else $error("skipped rail enabled");
  a_done_drop_first: assert property (@(posedge mclk)
    disable iff (!nrst) ($fell(sequence_complete_flag) && $past(por_s))
    |-> $past(s_q.idx) == RST_IDX_RST)
    else $error("done fell early");
  a_down_hold_delay: assert property (@(posedge mclk)
    disable iff (!nrst) (s_q.st == RST_DNDLY && !dly_done && por_s)
    |=> $stable(rail_enable))
    else $error("enable dropped in delay");
  a_en_ascend: assert property (@(posedge mclk)
    disable iff (!nrst) (s_q.st == RST_UPDLY && dly_done && !dn_evt
    && por_s && s_q.idx != top)
    |=> rail_enable == ($past(rail_enable) | $past(next_bit)))
    else $error("enable out of order");
  a_en_descend: assert property (@(posedge mclk)
    disable iff (!nrst) ((s_q.st == RST_DNWT || s_q.st == RST_DNDLY)
    && !up_evt && por_s)
    |=> (rail_enable & ~$past(rail_enable)) == 4'h0)
    else $error("enable rose in down");
  a_timeout_unwind: assert property (@(posedge mclk)
    disable iff (!nrst) (s_q.st == RST_UPWT && reg_if.expired && !dn_evt
    && !on_s[s_q.idx] && por_s)
    |=> (rail_enable & $past(cur_bit)) == 4'h0 && !power_good_flag)
    else $error("timeout ignored");
  // first enable only on up edge
  a_up_from_edge: assert property (@(posedge mclk)
    disable iff (!nrst) $rose(rail_enable[0]) |-> $past(up_evt))
    else $error("enable without up edge");
  a_dly_off_idle: assert property (@(posedge mclk)
    disable iff (!nrst) !step_delay_connected |-> !dly_if.running)
    else $error("delay timer ran while off");
  a_reg_off_idle: assert property (@(posedge mclk)
    disable iff (!nrst) !regulation_connected |-> !reg_if.running)
    else $error("timeout ran while off");
  a_done_at_top: assert property (@(posedge mclk)
    disable iff (!nrst) $rose(sequence_complete_flag)
    |-> $past(s_q.idx) == $past(top))
    else $error("complete before top rail");

  c_full_up: cover property (@(posedge mclk) $rose(power_good_flag));
  c_full_down: cover property (@(posedge mclk)
    $fell(sequence_complete_flag));
  c_timeout: cover property (@(posedge mclk) reg_if.expired);
  c_up_abort: cover property (@(posedge mclk)
    s_q.st == RST_UPDLY && dn_evt);
  c_skip_top: cover property (@(posedge mclk)
    skip_s[3] && $rose(sequence_complete_flag));
endmodule
`default_nettype wire

// file: bench/rst_reg_model.sv
// Regulator bank: each enabled rail ramps to its on level, then falls.
// Assumes the bench clock; stall keeps a rail under its off level.
`timescale 1ns/1ps
`default_nettype none
module rst_reg_model (
  input  wire logic        mclk,    // Bench clock
  input  wire logic        nrst,    // Reset, active low
  input  wire logic [3:0]  en,      // Regulator enables
  input  wire logic [3:0]  stall,   // Rail never regulates
  input  wire logic [15:0] ramp,    // Cycles to on level
  input  wire logic [15:0] fall,    // Cycles to off level
  output logic      [3:0]  on_lvl,  // Above on level
  output logic      [3:0]  off_lvl  // Below off level
);
  logic [3:0]  en_p;
  logic [15:0] cnt [4];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      en_p <= 4'h0;
      on_lvl <= 4'h0;
      off_lvl <= 4'hF;
      for (int i = 0; i < 4; i++) cnt[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (en[i] != en_p[i]) cnt[i] <= 16'h0000;
        else if (cnt[i] != 16'hFFFF) cnt[i] <= cnt[i] + 16'h0001;
        // Leaves the on level at once, reaches off level later
        on_lvl[i]  <= en[i] & en_p[i] & ~stall[i]
                      & (on_lvl[i] | cnt[i] >= ramp);
        off_lvl[i] <= en[i]
                      ? off_lvl[i] & (stall[i] | ~en_p[i] | cnt[i] < ramp)
                      : off_lvl[i] | (~en_p[i] & cnt[i] >= fall);
      end
      en_p <= en;
    end
  end
endmodule
`default_nettype wire

// file: bench/test_rail_sequence_timers.sv
// Self-checking bench for the rail sequencer with a regulator model.
// Assumes the design package and timer interface are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_rail_sequence_timers;
  import rst_pkg::*;
  logic        mclk, nrst, supply_ok, up_cmd, down_cmd_n, dly_on, reg_on;
  logic [3:0]  on_lvl, off_lvl, mon_tied, stall, en;
  logic [19:0] dly_cyc, reg_cyc;
  logic [15:0] ramp, fall;
  logic        done, pg;
  int          mismatches, tests_run, t, d;
  int          exp_q[$];

  rst_sequencer rst_sequencer_i (.mclk(mclk), .nrst(nrst),
    .main_supply_ok(supply_ok), .rail_on_level(on_lvl),
    .rail_off_level(off_lvl), .rail_monitor_input(mon_tied),
    .up_cmd(up_cmd), .down_cmd_n(down_cmd_n),
    .step_delay_connected(dly_on), .step_delay_cycles(dly_cyc),
    .regulation_connected(reg_on), .regulation_cycles(reg_cyc),
    .rail_enable(en), .sequence_complete_flag(done), .power_good_flag(pg));
  rst_reg_model rst_reg_model_i (.mclk(mclk), .nrst(nrst), .en(en),
    .stall(stall), .ramp(ramp), .fall(fall), .on_lvl(on_lvl),
    .off_lvl(off_lvl));

  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int got, input int lo, input int hi);
    tests_run++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("FAIL %0t cycles %h exp %h..%h", $time, got, lo, hi);
    end
  endtask

  function automatic logic [3:0] mask(input int k);
    return 4'((1 << k) - 1);
  endfunction

  // Bounded wait: sel 0 enables, 1 complete flag, 2 power-good flag
  task automatic wait_sig(input int sel, input logic [3:0] v, output int n);
    n = 0;
    while ((sel == 0 ? en : {3'h0, sel == 1 ? done : pg}) !== v) begin
      // Sample away from the edge that launches the outputs
      @(negedge mclk);
      n++;
      if (n > 30000) begin
        mismatches++;
        $display("FAIL %0t wait %h for %h", $time, sel, v);
        finish_test();
      end
    end
  endtask

  // timer settings only change while held in reset
  task automatic setup(input logic dl, input int dc, input logic rg,
                       input logic [3:0] mon, input logic [3:0] st);
    @(posedge mclk);
    nrst <= 1'b0;
    supply_ok <= 1'b1;
    dly_on <= dl;
    dly_cyc <= dc[19:0];
    reg_on <= rg;
    mon_tied <= mon;
    stall <= st;
    up_cmd <= 1'b0;
    down_cmd_n <= 1'b1;
    ramp <= 16'(20 + $urandom % 60);
    fall <= 16'(20 + $urandom % 60);
    repeat (3) @(posedge mclk);
    cmp({done, pg, en}, 6'h00);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic run_up(input int n, input int dl);
    int tt;
    for (int k = 1; k <= n; k++) exp_q.push_back(int'(mask(k)));
    up_cmd <= 1'b1;
    wait_sig(0, 4'(exp_q.pop_front()), tt);
    chk_time(tt, 1, RST_TPD_CYC);
    while (exp_q.size() > 0) begin
      wait_sig(0, 4'(exp_q.pop_front()), tt);
      chk_time(tt, ramp + dl, ramp + dl + RST_TPD_CYC);
      cmp({done, pg}, 2'h0);
    end
    wait_sig(1, 4'h1, tt);
    chk_time(tt, ramp + dl, ramp + dl + RST_TPD_CYC);
    cmp({pg, en}, {1'b1, mask(n)});
  endtask

  task automatic run_down(input int n, input int dl);
    int tt;
    @(posedge mclk);
    down_cmd_n <= 1'b0;
    up_cmd <= 1'b0;
    wait_sig(2, 4'h0, tt);
    chk_time(tt, 1, RST_TPD_CYC);
    for (int k = n - 1; k >= 0; k--) begin
      wait_sig(0, mask(k), tt);
      if (k == n - 1) chk_time(tt, 0, RST_TPD_CYC);
      else chk_time(tt, fall + dl, fall + dl + RST_TPD_CYC);
      cmp(done, 1'b1);
    end
    wait_sig(1, 4'h0, tt);
    chk_time(tt, fall + dl, fall + dl + RST_TPD_CYC);
    @(posedge mclk);
    down_cmd_n <= 1'b1;
  endtask

  initial begin
    repeat (100000) @(posedge mclk);
    mismatches++;
    $display("FAIL %0t run limit %h", $time, 100000);
    finish_test();
  end

  initial begin
    {nrst, supply_ok, up_cmd, dly_on, reg_on} = 5'h00;
    down_cmd_n = 1'b1;
    {mon_tied, stall, dly_cyc, ramp, fall} = 60'h0;
    reg_cyc = 20'(RST_TMIN_CYC);
    void'($urandom(32'h8BEB));
    setup(1'b0, 0, 1'b0, 4'h0, 4'h0);
    run_up(4, 0);
    run_down(4, 0);
    // Shortest legal delay plus a random margin, top channel tied off
    d = RST_TMIN_CYC + $urandom % 200;
    setup(1'b1, d, 1'b0, 4'h8, 4'h0);
    run_up(3, d);
    run_down(3, d);
    // second rail never regulates, timer unwinds
    setup(1'b0, 0, 1'b1, 4'h0, 4'h2);
    up_cmd <= 1'b1;
    wait_sig(0, 4'h3, t);
    wait_sig(0, 4'h0, t);
    chk_time(t, RST_TMIN_CYC, RST_TMIN_CYC + fall + 3 * RST_TPD_CYC);
    cmp({done, pg}, 2'h0);
    // without the timer the stuck rail waits on
    setup(1'b0, 0, 1'b0, 4'h0, 4'h2);
    up_cmd <= 1'b1;
    wait_sig(0, 4'h3, t);
    repeat (RST_TMIN_CYC + 500) @(negedge mclk);
    cmp({done, pg, en}, 6'h03);
    // supply loss forces every output low
    @(posedge mclk);
    supply_ok <= 1'b0;
    wait_sig(0, 4'h0, t);
    chk_time(t, 1, RST_TPD_CYC);
    cmp({done, pg}, 2'h0);
    finish_test();
  end
endmodule
`default_nettype wire
